// ==== rtl/vss_pkg.sv ====
// Purpose: Shared constants and carrier types for the sag and swell detector.
// Assumes: Magnitudes and samples arrive as unsigned volts and signed counts.
// Notes:   Percent figures are whole percent of the nominal voltage.
package vss_pkg;

    localparam int MAG_W  = 16;
    localparam int SMP_W  = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 12;
    localparam int PROD_W = 26;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_NOM    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SWELL  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SAG    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CHANGE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_HYST   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RANK   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CUTOFF = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_TRN    = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_STATE  = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_MAG    = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_DUR    = 8'h30;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [MAG_W-1:0] RST_NOM    = 16'h0000;
    localparam logic [7:0]       RST_SWELL  = 8'h6e;
    localparam logic [7:0]       RST_SAG    = 8'h5a;
    localparam logic [7:0]       RST_CHANGE = 8'h0a;
    localparam logic [7:0]       RST_HYST   = 8'h02;
    localparam logic [7:0]       RST_RANK   = 8'h00;
    localparam logic [7:0]       RST_CUTOFF = 8'h00;
    localparam logic [7:0]       RST_TRN    = 8'h7d;
    localparam logic [4:0]       RST_MASK   = 5'h00;
    localparam logic [7:0]       PCT_FULL   = 8'h64;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Status bit positions.
    localparam int EV_SAG   = 0;
    localparam int EV_SWELL = 1;
    localparam int EV_RPT   = 2;
    localparam int EV_TRN   = 3;
    localparam int EV_LOG   = 4;
    localparam int EV_N     = 5;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Capture geometry.
    localparam int SAG_SPC = 32;
    localparam int SAG_CYC = 54;
    localparam int TRN_SPC = 512;
    localparam int TRN_CYC = 4;

    typedef enum logic [1:0] {ST_IDLE, ST_SAG, ST_SWELL} vss_state_t;

    typedef struct packed {
        logic             valid;
        logic [MAG_W-1:0] value;
    } vss_mag_t;

    typedef struct packed {
        logic                    valid;
        logic signed [SMP_W-1:0] sample;
    } vss_wav_t;

    typedef struct packed {
        logic             valid;
        logic             sag;
        logic             sub;
        logic [7:0]       rank;
        logic [MAG_W-1:0] mag;
        logic [31:0]      dur;
    } vss_rpt_t;

    typedef struct packed {
        logic             valid;
        logic [IDX_W-1:0] index;
        logic [SMP_W-1:0] data;
    } vss_cap_t;

endpackage : vss_pkg

// ==== rtl/vss_detector.sv ====
// Purpose: Sag and swell detector with sub-disturbances, event log gate and captures.
// Assumes: One magnitude per I_MAG.valid, waveform samples at 512 per mains cycle.
// Notes:   Registers sit on a plain strobe port; read data follows one cycle later.
//
// How it works
// - Swell when magnitude above swell limit.
// - Sag when magnitude below sag limit.
// - New sub-disturbance on change of step.
// - Zero nominal voltage disables all detection.
// - Sag ends at sag limit plus hysteresis.
// - Events carry programmable rank, zero default.
// - Log only when rank exceeds cutoff.
// - Rank zero suppresses all log entries.
// - Report magnitude and duration per disturbance.
// - Sag capture: 32 samples, 54 cycles.
// - Transient capture: 512 samples, 4 cycles.
// - Transient threshold is 100 plus deviation.
`timescale 1ns/10ps
module vss_detector
#(
    parameter int SAG_SPC_P = vss_pkg::SAG_SPC,
    parameter int SAG_CYC_P = vss_pkg::SAG_CYC,
    parameter int TRN_SPC_P = vss_pkg::TRN_SPC,
    parameter int TRN_CYC_P = vss_pkg::TRN_CYC
)
(
    input  wire logic                        I_CLK,
    input  wire logic                        I_RST_B,
    input  wire logic [vss_pkg::ADDR_W-1:0]  I_ADDR,
    input  wire logic [vss_pkg::DATA_W-1:0]  I_WDATA,
    input  wire logic                        I_WR,
    input  wire logic                        I_RD,
    output logic      [vss_pkg::DATA_W-1:0]  O_RDATA,
    input  wire vss_pkg::vss_mag_t           I_MAG,
    input  wire vss_pkg::vss_wav_t           I_WAV,
    output vss_pkg::vss_rpt_t                O_RPT,
    output logic                             O_LOG_WR,
    output vss_pkg::vss_cap_t                O_SAG_CAP,
    output vss_pkg::vss_cap_t                O_TRN_CAP,
    output logic                             O_IRQ
);
    import vss_pkg::*;

    localparam int SAG_DEPTH = SAG_SPC_P * SAG_CYC_P;
    localparam int TRN_DEPTH = TRN_SPC_P * TRN_CYC_P;
    localparam int SAG_DIV   = TRN_SPC_P / SAG_SPC_P;
    localparam logic [IDX_W-1:0] SAG_LAST = IDX_W'(SAG_DEPTH - 1);
    localparam logic [IDX_W-1:0] TRN_LAST = IDX_W'(TRN_DEPTH - 1);
    localparam logic [IDX_W-1:0] DIV_LAST = IDX_W'(SAG_DIV - 1);

    logic [MAG_W-1:0] nom_volts;
    logic [7:0]       swell_lim;
    logic [7:0]       sag_lim;
    logic [7:0]       change_step;
    logic [7:0]       hyst;
    logic [7:0]       event_rank;
    logic [7:0]       cutoff;
    logic [7:0]       trn_thr;
    logic [EV_N-1:0]  status;
    logic [EV_N-1:0]  mask;
    logic [EV_N-1:0]  ev_set;
    vss_state_t       state;
    logic [MAG_W-1:0] ref_mag;
    logic [MAG_W-1:0] ext_mag;
    logic [31:0]      dur;
    logic             sag_start;
    logic             swell_start;
    logic             trn_evt;
    logic             sag_busy;
    logic             trn_busy;
    logic [IDX_W-1:0] sag_idx;
    logic [IDX_W-1:0] sag_phase;
    logic [IDX_W-1:0] trn_idx;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Percent comparisons, all scaled by the nominal voltage to avoid a divider.
    logic             pq_on;
    logic [PROD_W-1:0] m_pct;
    logic [PROD_W-1:0] sag_on_th;
    logic [PROD_W-1:0] sag_off_th;
    logic [PROD_W-1:0] swell_on_th;
    logic [PROD_W-1:0] swell_off_th;
    logic [PROD_W-1:0] step_th;
    logic [PROD_W-1:0] diff_pct;
    logic [PROD_W-1:0] trn_pct;
    logic [PROD_W-1:0] trn_th;
    logic [MAG_W-1:0]  diff;
    logic [SMP_W-1:0]  wav_abs;
    logic [8:0]        sag_end_pct;
    logic [7:0]        swell_end_pct;
    logic              is_sag;
    logic              is_swell;
    logic              sag_over;
    logic              swell_over;
    logic              step_hit;
    logic              trn_hit;

    assign pq_on         = (nom_volts != '0);
    assign sag_end_pct   = {1'b0, sag_lim} + {1'b0, hyst};
    assign swell_end_pct = (swell_lim > hyst) ? swell_lim - hyst : 8'h00;
    assign m_pct         = PROD_W'(I_MAG.value) * PROD_W'(PCT_FULL);
    assign sag_on_th     = PROD_W'(sag_lim) * PROD_W'(nom_volts);
    assign sag_off_th    = PROD_W'(sag_end_pct) * PROD_W'(nom_volts);
    assign swell_on_th   = PROD_W'(swell_lim) * PROD_W'(nom_volts);
    assign swell_off_th  = PROD_W'(swell_end_pct) * PROD_W'(nom_volts);
    assign step_th       = PROD_W'(change_step) * PROD_W'(nom_volts);
    assign diff          = (I_MAG.value >= ref_mag) ? I_MAG.value - ref_mag
                                                    : ref_mag - I_MAG.value;
    assign diff_pct      = PROD_W'(diff) * PROD_W'(PCT_FULL);
    assign wav_abs       = I_WAV.sample[SMP_W-1] ? SMP_W'(-I_WAV.sample)
                                                 : SMP_W'(I_WAV.sample);
    assign trn_pct       = PROD_W'(wav_abs) * PROD_W'(PCT_FULL);
    assign trn_th        = PROD_W'(trn_thr) * PROD_W'(nom_volts);

    assign is_sag     = m_pct < sag_on_th;
    assign is_swell   = m_pct > swell_on_th;
    assign sag_over   = m_pct >= sag_off_th;
    assign swell_over = m_pct <= swell_off_th;
    assign step_hit   = diff_pct >= step_th;
    assign trn_hit    = I_WAV.valid && pq_on && (trn_pct > trn_th);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            nom_volts   <= RST_NOM;
            swell_lim   <= RST_SWELL;
            sag_lim     <= RST_SAG;
            change_step <= RST_CHANGE;
            hyst        <= RST_HYST;
            event_rank  <= RST_RANK;
            cutoff      <= RST_CUTOFF;
            trn_thr     <= RST_TRN;
            mask        <= RST_MASK;
        end
        else if (I_WR)
        begin
            case (I_ADDR)
                OFS_NOM:    nom_volts   <= I_WDATA[MAG_W-1:0];
                OFS_SWELL:  swell_lim   <= I_WDATA[7:0];
                OFS_SAG:    sag_lim     <= I_WDATA[7:0];
                OFS_CHANGE: change_step <= I_WDATA[7:0];
                OFS_HYST:   hyst        <= I_WDATA[7:0];
                OFS_RANK:   event_rank  <= I_WDATA[7:0];
                OFS_CUTOFF: cutoff      <= I_WDATA[7:0];
                OFS_TRN:    trn_thr     <= I_WDATA[7:0];
                OFS_MASK:   mask        <= I_WDATA[EV_N-1:0];
                default:    ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Sticky status, cleared by a read; a new event in the same cycle survives.
    assign ev_set = {O_LOG_WR, trn_evt, O_RPT.valid, swell_start, sag_start};

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            status <= '0;
        end
        else if (I_RD && (I_ADDR == OFS_STATUS))
        begin
            status <= ev_set;
        end
        else
        begin
            status <= status | ev_set;
        end
    end

    assign O_IRQ = |(status & mask);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe; unmapped offsets read as zero.
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            O_RDATA <= '0;
        end
        else if (I_RD)
        begin
            case (I_ADDR)
                OFS_NOM:    O_RDATA <= DATA_W'(nom_volts);
                OFS_SWELL:  O_RDATA <= DATA_W'(swell_lim);
                OFS_SAG:    O_RDATA <= DATA_W'(sag_lim);
                OFS_CHANGE: O_RDATA <= DATA_W'(change_step);
                OFS_HYST:   O_RDATA <= DATA_W'(hyst);
                OFS_RANK:   O_RDATA <= DATA_W'(event_rank);
                OFS_CUTOFF: O_RDATA <= DATA_W'(cutoff);
                OFS_TRN:    O_RDATA <= DATA_W'(trn_thr);
                OFS_STATUS: O_RDATA <= DATA_W'(status);
                OFS_MASK:   O_RDATA <= DATA_W'(mask);
                OFS_STATE:  O_RDATA <= DATA_W'({trn_busy, sag_busy, state});
                OFS_MAG:    O_RDATA <= DATA_W'(O_RPT.mag);
                OFS_DUR:    O_RDATA <= O_RPT.dur;
                default:    O_RDATA <= '0;
            endcase
        end
        else
        begin
            O_RDATA <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Disturbance tracker, reports and log gate.
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            state       <= ST_IDLE;
            ref_mag     <= '0;
            ext_mag     <= '0;
            dur         <= '0;
            sag_start   <= 1'b0;
            swell_start <= 1'b0;
            O_RPT       <= '0;
            O_LOG_WR    <= 1'b0;
        end
        else
        begin
            sag_start   <= 1'b0;
            swell_start <= 1'b0;
            O_RPT.valid <= 1'b0;
            O_LOG_WR    <= 1'b0;
            if (!pq_on)
            begin
                state <= ST_IDLE;
            end
            else if (I_MAG.valid)
            begin
                case (state)
                    ST_IDLE:
                    begin
                        ref_mag <= I_MAG.value;
                        ext_mag <= I_MAG.value;
                        dur     <= 32'h00000001;
                        if (is_sag)
                        begin
                            state     <= ST_SAG;
                            sag_start <= 1'b1;
                        end
                        else if (is_swell)
                        begin
                            state       <= ST_SWELL;
                            swell_start <= 1'b1;
                        end
                    end
                    ST_SAG, ST_SWELL:
                    begin
                        if ((state == ST_SAG) ? sag_over : swell_over)
                        begin
                            state <= ST_IDLE;
                        end
                        if (((state == ST_SAG) ? sag_over : swell_over) || step_hit)
                        begin
                            O_RPT.valid <= 1'b1;
                            O_RPT.sag   <= (state == ST_SAG);
                            O_RPT.sub   <= !((state == ST_SAG) ? sag_over : swell_over);
                            O_RPT.rank  <= event_rank;
                            O_RPT.mag   <= ext_mag;
                            O_RPT.dur   <= dur;
                            O_LOG_WR    <= (event_rank != 8'h00)
                                           && (event_rank > cutoff);
                            ref_mag     <= I_MAG.value;
                            ext_mag     <= I_MAG.value;
                            dur         <= 32'h00000001;
                        end
                        else
                        begin
                            dur <= dur + 32'h00000001;
                            if ((state == ST_SAG) ? (I_MAG.value < ext_mag)
                                                  : (I_MAG.value > ext_mag))
                            begin
                                ext_mag <= I_MAG.value;
                            end
                        end
                    end
                    default:
                    begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Sag capture: every 16th waveform sample, SAG_DEPTH samples per sag.
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            sag_busy  <= 1'b0;
            sag_idx   <= '0;
            sag_phase <= '0;
            O_SAG_CAP <= '0;
        end
        else
        begin
            O_SAG_CAP.valid <= 1'b0;
            if (!sag_busy)
            begin
                sag_busy  <= sag_start;
                sag_idx   <= '0;
                sag_phase <= '0;
            end
            else if (I_WAV.valid)
            begin
                sag_phase <= (sag_phase == DIV_LAST) ? '0 : sag_phase + 1'b1;
                if (sag_phase == '0)
                begin
                    O_SAG_CAP.valid <= 1'b1;
                    O_SAG_CAP.index <= sag_idx;
                    O_SAG_CAP.data  <= I_WAV.sample;
                    sag_idx         <= sag_idx + 1'b1;
                    sag_busy        <= (sag_idx != SAG_LAST);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Transient capture: every waveform sample, TRN_DEPTH samples per trigger.
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            trn_busy  <= 1'b0;
            trn_idx   <= '0;
            trn_evt   <= 1'b0;
            O_TRN_CAP <= '0;
        end
        else
        begin
            O_TRN_CAP.valid <= 1'b0;
            trn_evt         <= trn_hit && !trn_busy;
            if (trn_hit || trn_busy)
            begin
                if (I_WAV.valid)
                begin
                    O_TRN_CAP.valid <= 1'b1;
                    O_TRN_CAP.index <= trn_busy ? trn_idx : '0;
                    O_TRN_CAP.data  <= I_WAV.sample;
                    trn_idx         <= trn_busy ? trn_idx + 1'b1 : IDX_W'(1);
                    trn_busy        <= !trn_busy || (trn_idx != TRN_LAST);
                end
            end
        end
    end

endmodule : vss_detector

// ==== test/vss_frontend.sv ====
// Purpose: Mains front end model: magnitude samples and a waveform.
// Assumes: One waveform sample every second clock, spike on request.
// Notes:   Between samples the wave bus shows the inverse of the last value.
`timescale 1ns/10ps
module vss_frontend
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_mag_req,
    input  wire logic [15:0] i_mag_val,
    input  wire logic [15:0] i_spike,
    output vss_pkg::vss_mag_t o_mag,
    output vss_pkg::vss_wav_t o_wav
);
    import vss_pkg::*;
    logic [5:0] phase;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_mag <= '0;
            o_wav <= '0;
            phase <= '0;
        end
        else
        begin
            o_mag <= {i_mag_req, i_mag_val};
            phase <= phase + 6'h01;
            o_wav.valid <= phase[0];
            if (!phase[0])
                o_wav.sample <= ~o_wav.sample;
            else if (i_spike != 16'h0000)
                o_wav.sample <= i_spike;
            else
                o_wav.sample <= {10'h000, phase} - 16'h0020;
        end
    end
endmodule : vss_frontend

// ==== test/vss_detector_properties.sv ====
// Purpose: Port level checks of the sag and swell detector.
// Assumes: Sag, swell and hysteresis settings stay at their reset values.
// Notes:   Nominal, rank and cutoff are shadowed from register writes.
`timescale 1ns/10ps
module vss_detector_properties
#(
    parameter int SAG_SPC_P = vss_pkg::SAG_SPC,
    parameter int SAG_CYC_P = vss_pkg::SAG_CYC,
    parameter int TRN_SPC_P = vss_pkg::TRN_SPC,
    parameter int TRN_CYC_P = vss_pkg::TRN_CYC
)
(
    input wire logic                       I_CLK,
    input wire logic                       I_RST_B,
    input wire logic [vss_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [vss_pkg::DATA_W-1:0] I_WDATA,
    input wire logic                       I_WR,
    input wire logic                       I_RD,
    input wire logic [vss_pkg::DATA_W-1:0] O_RDATA,
    input wire vss_pkg::vss_mag_t          I_MAG,
    input wire vss_pkg::vss_wav_t          I_WAV,
    input wire vss_pkg::vss_rpt_t          O_RPT,
    input wire logic                       O_LOG_WR,
    input wire vss_pkg::vss_cap_t          O_SAG_CAP,
    input wire vss_pkg::vss_cap_t          O_TRN_CAP,
    input wire logic                       O_IRQ
);
    import vss_pkg::*;
    localparam int IDX_S = SAG_SPC_P * SAG_CYC_P;
    localparam int IDX_T = TRN_SPC_P * TRN_CYC_P;
    logic [15:0] nom;
    logic [7:0]  rnk, cut;
    logic [31:0] sag_end, swl_end, rmag;
    logic        rv;
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            {nom, rnk, cut} <= {RST_NOM, RST_RANK, RST_CUTOFF};
        else if (I_WR && I_ADDR == OFS_NOM)
            nom <= I_WDATA[15:0];
        else if (I_WR && I_ADDR == OFS_RANK)
            rnk <= I_WDATA[7:0];
        else if (I_WR && I_ADDR == OFS_CUTOFF)
            cut <= I_WDATA[7:0];
    end
    assign sag_end = 32'(RST_SAG + RST_HYST) * 32'(nom);
    assign swl_end = 32'(RST_SWELL - RST_HYST) * 32'(nom);
    assign rmag = 32'(O_RPT.mag) * 32'h64;
    assign rv = O_RPT.valid;
    ////////////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    log_gate_a: assert property ((rv || O_LOG_WR) |->
        O_LOG_WR == (rv && O_RPT.rank > cut)) else $error("log write against rank");
    rank_tag_a: assert property (rv |-> O_RPT.rank == rnk)
        else $error("report rank differs");
    nom_off_a: assert property (nom == 16'h0 && $past(nom) == 16'h0 |-> !rv)
        else $error("report at zero nominal");
    sag_mag_a: assert property (rv && O_RPT.sag |-> rmag < sag_end)
        else $error("sag magnitude out of band");
    swl_mag_a: assert property (rv && !O_RPT.sag |-> rmag > swl_end)
        else $error("swell magnitude out of band");
    sag_done_a: assert property (rv && O_RPT.sag && !O_RPT.sub |->
        32'($past(I_MAG.value)) * 32'h64 >= sag_end) else $error("sag ended too low");
    swl_done_a: assert property (rv && !O_RPT.sag && !O_RPT.sub |->
        32'($past(I_MAG.value)) * 32'h64 <= swl_end) else $error("swell ended too high");
    dur_set_a: assert property (rv |-> $past(I_MAG.valid) && O_RPT.dur != 32'h0)
        else $error("no sample or duration");
    sag_cap_a: assert property (O_SAG_CAP.valid |-> O_SAG_CAP.index < IDX_S &&
        $past(I_WAV.valid) && O_SAG_CAP.data == $past(I_WAV.sample)) else $error("sag capture");
    trn_cap_a: assert property (O_TRN_CAP.valid |-> O_TRN_CAP.index < IDX_T &&
        $past(I_WAV.valid) && O_TRN_CAP.data == $past(I_WAV.sample)) else $error("trn capture");
    sag_rpt_c: cover property (rv && O_RPT.sag && !O_RPT.sub);
    swl_sub_c: cover property (rv && !O_RPT.sag && O_RPT.sub);
    log_c: cover property (O_LOG_WR);
    trn_c: cover property (O_TRN_CAP.valid && O_TRN_CAP.index == 12'h000);
endmodule : vss_detector_properties
bind vss_detector vss_detector_properties #(.SAG_SPC_P(SAG_SPC_P), .SAG_CYC_P(SAG_CYC_P),
    .TRN_SPC_P(TRN_SPC_P), .TRN_CYC_P(TRN_CYC_P)) u_props (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_MAG(I_MAG), .I_WAV(I_WAV), .O_RPT(O_RPT), .O_LOG_WR(O_LOG_WR),
    .O_SAG_CAP(O_SAG_CAP), .O_TRN_CAP(O_TRN_CAP), .O_IRQ(O_IRQ));

// ==== test/vss_detector_test.sv ====
// Purpose: Self-checking bench for the sag and swell detector.
// Assumes: Short capture depths; nominal of 100 makes volts read as percent.
// Notes:   A monitor queues reports for in-order compare.
`timescale 1ns/10ps
module vss_detector_test;
    import vss_pkg::*;
    localparam int NS = 8;
    localparam int NT = 32;
    logic        I_CLK, I_RST_B, I_WR, I_RD, mreq, O_LOG_WR, O_IRQ, lq[$];
    logic [7:0]  I_ADDR, ra [13], rk [4];
    logic [15:0] mval, spike, v;
    logic [31:0] I_WDATA, O_RDATA, rv, lfsr, re [13];
    vss_mag_t    I_MAG;
    vss_wav_t    I_WAV;
    vss_rpt_t    O_RPT, rq[$];
    vss_cap_t    O_SAG_CAP, O_TRN_CAP;
    int          fail_count, num_checks, cyc, ns, nt;
    vss_detector #(.SAG_SPC_P(4), .SAG_CYC_P(2), .TRN_SPC_P(16), .TRN_CYC_P(2)) u_dut
        (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
        .I_RD(I_RD), .O_RDATA(O_RDATA), .I_MAG(I_MAG), .I_WAV(I_WAV), .O_RPT(O_RPT),
        .O_LOG_WR(O_LOG_WR), .O_SAG_CAP(O_SAG_CAP), .O_TRN_CAP(O_TRN_CAP), .O_IRQ(O_IRQ));
    vss_frontend u_fe (.i_clk(I_CLK), .i_rst_b(I_RST_B), .i_mag_req(mreq), .i_mag_val(mval),
        .i_spike(spike), .o_mag(I_MAG), .o_wav(I_WAV));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction : nxt
    function automatic logic exp_log(input logic [7:0] k);
        return k != 8'h00 && k > 8'hc8;
    endfunction : exp_log
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'b1;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_RD <= 1'b1;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        @(negedge I_CLK);
        rv = O_RDATA;
    endtask : rd
    task automatic mag(input logic [15:0] m);
        @(posedge I_CLK);
        mreq <= 1'b1;
        mval <= m;
        @(posedge I_CLK);
        mreq <= 1'b0;
    endtask : mag
    task automatic poke(input logic [15:0] m);
        @(posedge I_CLK);
        spike <= m;
        repeat (2) @(posedge I_CLK);
        spike <= 16'h0000;
    endtask : poke
    task automatic chk_rpt(input logic [17:0] e, input logic [31:0] d, input logic [7:0] k);
        vss_rpt_t r;
        chk("report count", 32'h1, {31'h0, rq.size() != 0});
        if (rq.size() == 0)
            return;
        r = rq.pop_front();
        chk("report kind", {14'h0, e}, {14'h0, r.sag, r.sub, r.mag});
        chk("report dur", d, r.dur);
        chk("report rank", {24'h0, k}, {24'h0, r.rank});
        chk("log write", {31'h0, exp_log(k)}, {31'h0, lq.pop_front()});
    endtask : chk_rpt
    task results;
        if (fail_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        I_CLK = 1'b0;
        forever #2.5 I_CLK = ~I_CLK;
    end
    always @(posedge I_CLK)
    begin
        cyc++;
        if (O_RPT.valid === 1'b1)
        begin
            rq.push_back(O_RPT);
            lq.push_back(O_LOG_WR);
        end
        ns += (O_SAG_CAP.valid === 1'b1);
        nt += (O_TRN_CAP.valid === 1'b1);
        if (cyc == 3000)
        begin
            fail_count++;
            results();
        end
    end
    initial
    begin
        {I_RST_B, I_WR, I_RD, mreq, I_ADDR, I_WDATA, mval, spike} = '0;
        {fail_count, num_checks, cyc, ns, nt} = '0;
        lfsr = 32'hdcc00404;
        ra = '{OFS_NOM, OFS_SWELL, OFS_SAG, OFS_CHANGE, OFS_HYST, OFS_RANK, OFS_CUTOFF,
            OFS_TRN, OFS_MASK, OFS_STATE, OFS_MAG, OFS_DUR, 8'h3c};
        re = '{32'h0, 32'h6e, 32'h5a, 32'h0a, 32'h02, 32'h0, 32'h0, 32'h7d, 32'h0,
            32'h0, 32'h0, 32'h0, 32'h0};
        rk = '{8'h00, 8'hc8, 8'hc9, 8'hff};
        repeat (3) @(posedge I_CLK);
        I_RST_B <= 1'b1;
        for (int i = 0; i < 13; i++)
        begin
            rd(ra[i]);
            chk("reset value", re[i], rv);
        end
        mag(16'h000a);
        mag(16'h00c8);
        poke(16'h0200);
        repeat (80) @(posedge I_CLK);
        rd(OFS_STATUS);
        chk("status", 32'h0, rv);
        chk("captures", 32'h0, ns + nt);
        wr(OFS_NOM, 32'h64);
        wr(OFS_MASK, 32'h1f);
        wr(OFS_CUTOFF, 32'hc8);
        wr(OFS_RANK, 32'hc9);
        mag(16'h0055);
        mag(16'h005b);
        mag(16'h005d);
        repeat (4) @(posedge I_CLK);
        chk_rpt({2'b10, 16'h0055}, 32'h2, 8'hc9);
        chk("irq", 32'h1, {31'h0, O_IRQ});
        rd(OFS_STATUS);
        chk("status", 32'h15, rv);
        chk("irq", 32'h0, {31'h0, O_IRQ});
        repeat (80) @(posedge I_CLK);
        chk("sag captures", NS, ns);
        mag(16'h006f);
        mag(16'h006d);
        mag(16'h0082);
        mag(16'h006c);
        repeat (4) @(posedge I_CLK);
        chk_rpt({2'b01, 16'h006f}, 32'h2, 8'hc9);
        chk_rpt({2'b00, 16'h0082}, 32'h1, 8'hc9);
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_RANK, {24'h0, rk[i]});
            lfsr = nxt(lfsr);
            v = 16'h0032 + 16'(lfsr % 32'd39);
            mag(v);
            mag(16'h005f);
            repeat (4) @(posedge I_CLK);
            chk_rpt({2'b10, v}, 32'h1, rk[i]);
        end
        repeat (80) @(posedge I_CLK);
        rd(OFS_STATUS);
        nt = 0;
        poke(16'h007d);
        repeat (8) @(posedge I_CLK);
        rd(OFS_STATUS);
        chk("status", 32'h0, rv);
        poke(16'h007e);
        repeat (80) @(posedge I_CLK);
        rd(OFS_STATUS);
        chk("status", 32'h8, rv);
        chk("trn captures", NT, nt);
        chk("extra reports", 32'h0, rq.size());
        results();
    end
endmodule : vss_detector_test
